// ===== bench/gcm_fabric_model.sv
// Partner model: clock pins, routing lines and user fabric around the block
`timescale 1ns/10ps
`default_nettype none
module gcm_fabric_model
    import gcm_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 loop_clk,
    input  wire logic                 lock,
    output logic [NUM_PINS-1:0]       clk_pin,
    output logic [NUM_ROUTE-1:0]      route_in,
    output logic                      ref_pin,
    output logic                      fb_pin,
    output logic                      gated_clk
);
    logic [4:0]  tick_reg;
    logic [11:0] lfsr_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= 5'h0;
            lfsr_reg <= 12'hACE;
        end else begin
            tick_reg <= tick_reg + 5'h1;
            lfsr_reg <= {lfsr_reg[10:0], ^(lfsr_reg & 12'h829)};
        end
    end
    // Distinct rates per pin so a wrong selection shows on the net
    assign clk_pin   = {tick_reg[4], tick_reg[0], tick_reg[2], tick_reg[1]};
    assign ref_pin   = tick_reg[3];
    assign route_in  = {lfsr_reg[11:1], tick_reg[3]};
    assign fb_pin    = loop_clk;
    // Fabric ignores the loop clock until lock is back
    assign gated_clk = loop_clk & lock;
endmodule // gcm_fabric_model
`default_nettype wire

// ===== bench/gcm_tb_top.sv
// Testbench: register access, source selection and loop lock scenarios
`timescale 1ns/10ps
`default_nettype none
module gcm_tb_top;
    import gcm_pkg::*;
    localparam logic RD = 1'b0;
    localparam logic WR = 1'b1;
    logic                 pclk, presetn, psel, penable, pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rd_data, sel;
    logic                 pready, pslverr, err_bit, lock, loop_clk, sec_clk;
    logic [NUM_PINS-1:0]  clk_pin;
    logic [NUM_ROUTE-1:0] route_in;
    logic                 ref_pin, fb_pin;
    logic [NUM_NETS-1:0]  primary_clk, secondary_clk;
    int                   n_fail, n_checks, edges, highs;
    logic [31:0] rst_tab [6] = '{32'h0, DIV_RST, PHASE_RST, 32'h0, GSEL_RST,
                                 {16'h0, VCO_HALF_RST, 8'h00}};
    logic [31:0] cfg_ctrl [4] = '{32'h01, 32'h07, 32'h09, 32'h3D};
    logic [31:0] cfg_div [4] = '{32'h0300_0000, 32'h100, 32'h1_0001, 32'h1};
    int          exp_edge [4] = '{80, 160, 40, 40};
    int          exp_high [4] = '{320, 640, 640, 640};

    gcm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_pin(clk_pin), .route_in(route_in), .ref_pin(ref_pin),
        .fb_pin(fb_pin), .primary_clk(primary_clk),
        .secondary_clk(secondary_clk), .primary_loop_clock_out(loop_clk),
        .secondary_loop_clock_out(sec_clk), .lock(lock));
    gcm_fabric_model u_fabric (.pclk(pclk), .presetn(presetn),
        .loop_clk(loop_clk), .lock(lock), .clk_pin(clk_pin),
        .route_in(route_in), .ref_pin(ref_pin), .fb_pin(fb_pin),
        .gated_clk());

    task automatic judge(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // One APB transfer; write answers carry zero data as well
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic e,
                        input logic [31:0] x);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_data = prdata;
        err_bit = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        judge({err_bit, rd_data} === {e, x},
              $sformatf("addr %h got %b/%h", a, err_bit, rd_data));
    endtask
    task automatic wait_lock();
        int n;
        n = 0;
        while (lock !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        judge(n >= LOCK_SETTLE_CYCLES - 2 && n < 5000,
              $sformatf("lock after %0d cycles", n));
    endtask
    task automatic measure();
        logic last;
        edges = 0;
        highs = 0;
        last  = loop_clk;
        repeat (640) begin
            @(posedge pclk);
            edges += int'(loop_clk !== last);
            highs += int'(sec_clk === 1'b1);
            last = loop_clk;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (80000) @(posedge pclk);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_fail   = 0;
        n_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) xfer(RD, 8'(4 * i), 0, 0, rst_tab[i]);
        xfer(RD, 8'h18, 0, 1'b1, 0);
        xfer(WR, ADDR_STATUS, 32'hFFFF_FFFF, 1'b1, 0);
        for (int k = 0; k < 13; k++) begin
            sel = {12'h321, 4'(k), 12'h321, 4'(k)};
            xfer(WR, ADDR_GSEL, sel, 0, 0);
            repeat (30) @(posedge pclk);
            xfer(RD, ADDR_GSEL, 0, 0, sel);
        end
        xfer(WR, ADDR_PHASE, 32'h200, 0, 0);
        for (int c = 0; c < 4; c++) begin
            xfer(WR, ADDR_CTRL, 0, 0, 0);
            xfer(WR, ADDR_DIV, cfg_div[c], 0, 0);
            sel = (c == 1) ? 32'h3210_321D : GSEL_RST;
            xfer(WR, ADDR_GSEL, sel, 0, 0);
            xfer(WR, ADDR_CTRL, cfg_ctrl[c], 0, 0);
            wait_lock();
            measure();
            judge(edges >= exp_edge[c] - 6 && edges <= exp_edge[c] + 6,
                  $sformatf("loop edges %0d", edges));
            judge(highs >= exp_high[c] - 40 && highs <= exp_high[c] + 40,
                  $sformatf("secondary high %0d", highs));
            xfer(WR, ADDR_DIV, 0, 1'b1, 0);
            xfer(WR, ADDR_CTRL, 32'h3F, 0, 0);
            xfer(RD, ADDR_CTRL, 0, 0, cfg_ctrl[c]);
            xfer(RD, ADDR_DIV, 0, 0, cfg_div[c]);
        end
        xfer(WR, ADDR_DELAY, 32'h5, 0, 0);
        repeat (3) @(posedge pclk);
        judge(lock === 1'b0, "lock kept over delay change");
        wait_lock();
        xfer(RD, ADDR_DELAY, 0, 0, 32'h5);
        xfer(WR, ADDR_CTRL, 0, 0, 0);
        xfer(WR, ADDR_CTRL, 32'h11, 0, 0);
        wait_lock();
        xfer(WR, ADDR_DELAY, 32'h9, 0, 0);
        xfer(RD, ADDR_DELAY, 0, 0, 32'h5);
        judge(lock === 1'b1, "lock lost on ignored delay write");
        complete_run();
    end
endmodule // gcm_tb_top

bind gcm_top gcm_top_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_pin(clk_pin), .route_in(route_in), .primary_clk(primary_clk),
    .secondary_clk(secondary_clk), .lock(lock));
`default_nettype wire

// ===== bench/gcm_top_properties.sv
// Checker: port-level properties of the clock selection block
`timescale 1ns/10ps
`default_nettype none
module gcm_top_properties
    import gcm_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [NUM_PINS-1:0]   clk_pin,
    input wire logic [NUM_ROUTE-1:0]  route_in,
    input wire logic [NUM_NETS-1:0]   primary_clk,
    input wire logic [NUM_NETS-1:0]   secondary_clk,
    input wire logic                  lock
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        en_reg;
    logic        dyn_reg;
    logic [31:0] gsel_reg;
    logic [2:0]  gsel_age;
    logic [2:0]  off_age;
    logic [8:0]  open_cnt;
    logic [12:0] cand_d1, cand_d2, cand_d3;
    wire         taken = psel && penable && !pready;
    wire         wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire  [12:0] cand  = {route_in[8:0], clk_pin};
    wire  [3:0]  sel_p = gsel_reg[3:0];
    wire  [3:0]  p_ok, s_ok;
    for (genvar g = 0; g < NUM_NETS; g++) begin : g_net
        assign p_ok[g] = gsel_reg[4*g +: 4] > 4'hC
                         || primary_clk[g] == cand_d3[gsel_reg[4*g +: 4]];
        assign s_ok[g] = gsel_reg[16+4*g +: 4] > 4'hC
                         || secondary_clk[g] == cand_d3[gsel_reg[16+4*g +: 4]];
    end
    wire         gsel_wr = wr_ok && paddr == ADDR_GSEL;
    // Shadow copy lags the design by one edge; net checks wait 7 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg   <= 1'b0;
            dyn_reg  <= 1'b0;
            gsel_reg <= GSEL_RST;
        end else if (wr_ok && paddr == ADDR_CTRL) begin
            en_reg  <= pwdata[0];
            dyn_reg <= en_reg ? dyn_reg : pwdata[5];
        end else if (gsel_wr) begin
            gsel_reg <= pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gsel_age <= 3'h0;
            off_age  <= 3'h0;
            open_cnt <= 9'h0;
        end else begin
            gsel_age <= gsel_wr ? 3'h0 : gsel_age + 3'(gsel_age != 3'h7);
            off_age  <= en_reg ? 3'h0 : off_age + 3'(off_age != 3'h7);
            open_cnt <= lock ? 9'h0 : open_cnt + 9'(open_cnt != 9'h1FF);
        end
    end
    always_ff @(posedge pclk) begin
        {cand_d3, cand_d2, cand_d1} <= {cand_d2, cand_d1, cand};
    end
    chk_access_answer: assert property (taken |=> pready)
        else $error("no answer one cycle after access");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_status_ro:
        assert property (taken && pwrite && paddr == ADDR_STATUS
                         |=> pready && pslverr)
        else $error("status write not refused");
    chk_unmapped_err:
        assert property (taken && (paddr > ADDR_STATUS || paddr[1:0] != 2'h0)
                         |=> pslverr)
        else $error("unmapped access not refused");
    chk_frozen_cfg:
        assert property (taken && pwrite && en_reg && (paddr == ADDR_DIV ||
                         paddr == ADDR_PHASE || paddr == ADDR_GSEL) |=> pslverr)
        else $error("config write accepted while loop runs");
    chk_net_primary:
        assert property (gsel_age == 3'h7 |-> &p_ok)
        else $error("primary net does not follow its source");
    chk_net_second:
        assert property (gsel_age == 3'h7 |-> &s_ok)
        else $error("secondary net does not follow its source");
    chk_lock_settle:
        assert property ($rose(lock) |-> open_cnt >= 9'(LOCK_SETTLE_CYCLES))
        else $error("lock rose before settle time");
    chk_lock_delay_drop:
        assert property (wr_ok && paddr == ADDR_DELAY && en_reg && dyn_reg
                         |-> ##[0:3] !lock)
        else $error("lock held over a dynamic delay change");
    chk_lock_off: assert property (off_age == 3'h7 |-> !lock)
        else $error("lock high with loop disabled");
    cover property ($rose(lock));
    cover property (wr_ok && paddr == ADDR_DELAY && dyn_reg);
    cover property (pready && pslverr);
    cover property (gsel_age == 3'h6 && sel_p > 4'h3);
endmodule // gcm_top_properties
`default_nettype wire

// ===== src/gcm_pkg.sv
// Package: register map, field layout, reset values and timing for gcm
package gcm_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DIV    = 8'h04;
    localparam logic [7:0] ADDR_PHASE  = 8'h08;
    localparam logic [7:0] ADDR_DELAY  = 8'h0C;
    localparam logic [7:0] ADDR_GSEL   = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    localparam int          NUM_NETS     = 4;
    localparam int          NUM_PINS     = 4;
    localparam int          NUM_ROUTE    = 12;
    localparam int          ROUTE_W_LOOP = 9;
    localparam logic        LOOP_PRESENT = 1'b1;
    localparam int          SYNC_W       = NUM_PINS + NUM_ROUTE + 2;

    // Feedback source encodings
    localparam logic [1:0]  FB_INTERNAL  = 2'h0;
    localparam logic [1:0]  FB_GLOBAL    = 2'h1;
    localparam logic [1:0]  FB_POST      = 2'h2;
    localparam logic [1:0]  FB_EXTERNAL  = 2'h3;

    // ------------------------------------------------------------
    // Reset values and oscillator half-period limits
    // ------------------------------------------------------------
    localparam logic [7:0]  VCO_HALF_RST = 8'h10;
    localparam logic [7:0]  VCO_HALF_MIN = 8'h01;
    localparam logic [7:0]  VCO_HALF_MAX = 8'hFF;
    localparam logic [31:0] DIV_RST      = 32'h0000_0000;
    localparam logic [31:0] PHASE_RST    = 32'h0000_0100;
    localparam logic [31:0] GSEL_RST     = 32'h3210_3210;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ            = 200;
    localparam int          LOCK_SETTLE_NS     = 1000;
    localparam int          LOCK_SETTLE_CYCLES =
        (LOCK_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [11:0] LOCK_CNT_MAX = 12'(LOCK_SETTLE_CYCLES);

    // ------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [25:0] rsvd;
        logic        dly_dynamic;
        logic        dly_fb_path;
        logic [1:0]  fb_sel;
        logic        ref_route;
        logic        pll_en;
    } gcm_ctrl_t;

    typedef struct packed {
        logic [3:0] rsvd3;
        logic [3:0] sec_div;
        logic [3:0] rsvd2;
        logic [3:0] post_div;
        logic [3:0] rsvd1;
        logic [3:0] fb_div;
        logic [3:0] rsvd0;
        logic [3:0] in_div;
    } gcm_div_t;

    typedef enum logic [1:0] {
        LK_OFF    = 2'b00,
        LK_ACQ    = 2'b01,
        LK_LOCKED = 2'b11
    } gcm_lock_t;

endpackage

// ===== src/gcm_top.sv
// Global clock selection and loop synthesis control with APB registers
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module gcm_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [gcm_pkg::NUM_PINS-1:0]  clk_pin,
    input  wire logic [gcm_pkg::NUM_ROUTE-1:0] route_in,
    input  wire logic                       ref_pin,
    input  wire logic                       fb_pin,
    output logic [gcm_pkg::NUM_NETS-1:0]    primary_clk,
    output logic [gcm_pkg::NUM_NETS-1:0]    secondary_clk,
    output logic                            primary_loop_clock_out,
    output logic                            secondary_loop_clock_out,
    output logic                            lock
);
    import gcm_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    wire  [SYNC_W-1:0] raw_in = {fb_pin, ref_pin, route_in, clk_pin};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    wire [NUM_PINS-1:0]  pin_s   = sync2_reg[NUM_PINS-1:0];
    wire [NUM_ROUTE-1:0] route_s = sync2_reg[NUM_PINS+NUM_ROUTE-1:NUM_PINS];
    wire                 ref_p_s = sync2_reg[SYNC_W-2];
    wire                 fb_p_s  = sync2_reg[SYNC_W-1];

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    gcm_ctrl_t   ctrl_reg;
    gcm_div_t    div_reg;
    logic [31:0] phase_reg;
    logic [3:0]  delay_reg;
    logic [31:0] gsel_reg;
    logic [7:0]  vco_half_reg;
    gcm_lock_t   lock_state_reg;

    wire acc       = psel && penable && !pready;
    wire wr        = acc && pwrite;
    wire hit_ctrl  = paddr == ADDR_CTRL;
    wire hit_div   = paddr == ADDR_DIV;
    wire hit_phase = paddr == ADDR_PHASE;
    wire hit_delay = paddr == ADDR_DELAY;
    wire hit_gsel  = paddr == ADDR_GSEL;
    wire hit_stat  = paddr == ADDR_STATUS;
    wire mapped    = hit_ctrl | hit_div | hit_phase | hit_delay
                   | hit_gsel | hit_stat;
    // Ratio and selector registers are frozen while the loop runs
    wire frozen    = ctrl_reg.pll_en;
    wire cfg_hit   = hit_div | hit_phase | hit_gsel;
    wire wr_err    = pwrite && (hit_stat || (cfg_hit && frozen));
    wire err       = !mapped || wr_err;
    wire wr_ok     = wr && !err;
    wire dly_wr    = wr_ok && hit_delay && (!frozen || ctrl_reg.dly_dynamic);

    wire [31:0] rd_mux =
        hit_ctrl  ? 32'(ctrl_reg) :
        hit_div   ? 32'(div_reg) :
        hit_phase ? phase_reg :
        hit_delay ? {28'h0000000, delay_reg} :
        hit_gsel  ? gsel_reg :
        hit_stat  ? {16'h0000, vco_half_reg, 7'h00, lock} :
                    32'h0000_0000;

    // Only the enable may change while running; other fields hold
    gcm_ctrl_t ctrl_wr;
    assign ctrl_wr = frozen ? gcm_ctrl_t'({ctrl_reg[31:1], pwdata[0]})
                            : gcm_ctrl_t'({26'h0000000, pwdata[5:0]});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc && err;
            prdata  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= gcm_ctrl_t'(32'h0000_0000);
            div_reg   <= gcm_div_t'(DIV_RST);
            phase_reg <= PHASE_RST;
            delay_reg <= 4'h0;
            gsel_reg  <= GSEL_RST;
        end else if (wr_ok) begin
            if (hit_ctrl)  ctrl_reg  <= ctrl_wr;
            if (hit_div)   div_reg   <= gcm_div_t'(pwdata);
            if (hit_phase) phase_reg <= {20'h00000, pwdata[11:8],
                                         4'h0, pwdata[3:0]};
            // Delay stays writable while running only in dynamic mode
            if (hit_delay && (!frozen || ctrl_reg.dly_dynamic))
                delay_reg <= pwdata[3:0];
            if (hit_gsel)  gsel_reg  <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // Loop reference and input divider
    // ------------------------------------------------------------
    logic ref_prev_reg;
    logic fb_prev_reg;
    logic [3:0] in_cnt_reg;
    logic [3:0] fb_cnt_reg;

    wire ref_src  = ctrl_reg.ref_route ? route_s[0] : ref_p_s;
    wire ref_rise = ref_src && !ref_prev_reg;
    wire in_tick  = ref_rise && (in_cnt_reg == div_reg.in_div);

    logic vco_reg;
    logic clkop_reg;
    logic secondary_loop_clock_out_reg;
    wire  fb_src =
        (ctrl_reg.fb_sel == FB_INTERNAL) ? vco_reg :
        (ctrl_reg.fb_sel == FB_GLOBAL)   ? primary_clk[0] :
        (ctrl_reg.fb_sel == FB_POST)     ? clkop_reg :
                                           fb_p_s;
    wire fb_rise = fb_src && !fb_prev_reg;
    wire fb_tick = fb_rise && (fb_cnt_reg == div_reg.fb_div);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev_reg <= 1'b0;
            fb_prev_reg  <= 1'b0;
            in_cnt_reg   <= 4'h0;
            fb_cnt_reg   <= 4'h0;
        end else begin
            ref_prev_reg <= ref_src;
            fb_prev_reg  <= fb_src;
            if (ref_rise)
                in_cnt_reg <= in_tick ? 4'h0 : in_cnt_reg + 4'h1;
            if (fb_rise)
                fb_cnt_reg <= fb_tick ? 4'h0 : fb_cnt_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Path delay, placed on input or feedback side
    // ------------------------------------------------------------
    // One delay unit; a second event inside the delay restarts it,
    // so delays must stay shorter than the divided period
    logic [3:0] dly_cnt_reg;
    wire dly_in  = ctrl_reg.dly_fb_path ? fb_tick : in_tick;
    wire dly_out = (dly_in && delay_reg == 4'h0) || dly_cnt_reg == 4'h1;
    wire ref_ev  = ctrl_reg.dly_fb_path ? in_tick : dly_out;
    wire fb_ev   = ctrl_reg.dly_fb_path ? dly_out : fb_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dly_cnt_reg <= 4'h0;
        else if (dly_in && delay_reg != 4'h0)
            dly_cnt_reg <= delay_reg;
        else if (dly_cnt_reg != 4'h0)
            dly_cnt_reg <= dly_cnt_reg - 4'h1;
    end

    // ------------------------------------------------------------
    // Frequency detector and oscillator
    // ------------------------------------------------------------
    logic [1:0]  fb_seen_reg;
    logic [7:0]  vco_cnt_reg;
    wire too_slow = ref_ev && fb_seen_reg == 2'h0;
    wire too_fast = ref_ev && fb_seen_reg > 2'h1;
    wire matched  = ref_ev && fb_seen_reg == 2'h1;
    wire vco_edge = ctrl_reg.pll_en && vco_cnt_reg >= vco_half_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_seen_reg  <= 2'h0;
            vco_half_reg <= VCO_HALF_RST;
            vco_cnt_reg  <= 8'h00;
            vco_reg      <= 1'b0;
        end else if (!ctrl_reg.pll_en) begin
            fb_seen_reg  <= 2'h0;
            vco_half_reg <= VCO_HALF_RST;
            vco_cnt_reg  <= 8'h00;
            vco_reg      <= 1'b0;
        end else begin
            if (ref_ev)
                fb_seen_reg <= {1'b0, fb_ev};
            else if (fb_ev && fb_seen_reg != 2'h3)
                fb_seen_reg <= fb_seen_reg + 2'h1;
            // Feedback divider ratio ends up as the multiplication
            if (too_slow && vco_half_reg > VCO_HALF_MIN)
                vco_half_reg <= vco_half_reg - 8'h01;
            else if (too_fast && vco_half_reg < VCO_HALF_MAX)
                vco_half_reg <= vco_half_reg + 8'h01;
            vco_cnt_reg <= vco_edge ? 8'h00 : vco_cnt_reg + 8'h01;
            if (vco_edge)
                vco_reg <= !vco_reg;
        end
    end

    // ------------------------------------------------------------
    // Post-scaler and secondary divider with phase and duty
    // ------------------------------------------------------------
    logic [3:0] post_cnt_reg;
    logic [3:0] sec_cnt_reg;
    wire post_edge = vco_edge && post_cnt_reg == div_reg.post_div;
    wire op_rise   = post_edge && !clkop_reg;
    wire [3:0] phase = phase_reg[3:0];
    wire [3:0] duty  = phase_reg[11:8];
    wire [4:0] sec_pos = (sec_cnt_reg >= phase)
        ? {1'b0, sec_cnt_reg - phase}
        : {1'b0, sec_cnt_reg} + {1'b0, div_reg.sec_div} + 5'h01
          - {1'b0, phase};
    wire [3:0] sec_nxt = (sec_cnt_reg == div_reg.sec_div) ? 4'h0
                                                          : sec_cnt_reg + 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_cnt_reg <= 4'h0;
            clkop_reg    <= 1'b0;
            sec_cnt_reg  <= 4'h0;
            secondary_loop_clock_out_reg    <= 1'b0;
        end else begin
            if (vco_edge)
                post_cnt_reg <= post_edge ? 4'h0 : post_cnt_reg + 4'h1;
            if (post_edge)
                clkop_reg <= !clkop_reg;
            if (op_rise)
                sec_cnt_reg <= sec_nxt;
            secondary_loop_clock_out_reg <= ctrl_reg.pll_en && (sec_pos < {1'b0, duty});
        end
    end

    // ------------------------------------------------------------
    // Lock detection
    // ------------------------------------------------------------
    logic [11:0] settle_cnt_reg;
    wire disturb = too_slow || too_fast || dly_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_state_reg <= LK_OFF;
            settle_cnt_reg <= 12'h000;
        end else begin
            case (lock_state_reg)
                LK_OFF: begin
                    settle_cnt_reg <= 12'h000;
                    if (ctrl_reg.pll_en)
                        lock_state_reg <= LK_ACQ;
                end
                LK_ACQ: begin
                    if (!ctrl_reg.pll_en)
                        lock_state_reg <= LK_OFF;
                    else if (disturb)
                        settle_cnt_reg <= 12'h000;
                    else if (settle_cnt_reg >= LOCK_CNT_MAX && matched)
                        lock_state_reg <= LK_LOCKED;
                    else if (settle_cnt_reg < LOCK_CNT_MAX)
                        settle_cnt_reg <= settle_cnt_reg + 12'h001;
                end
                LK_LOCKED: begin
                    settle_cnt_reg <= 12'h000;
                    if (!ctrl_reg.pll_en)
                        lock_state_reg <= LK_OFF;
                    else if (disturb)
                        lock_state_reg <= LK_ACQ;
                end
                default: lock_state_reg <= LK_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Global clock selection
    // ------------------------------------------------------------
    wire  [15:0] cand;
    assign cand[NUM_PINS-1:0] = pin_s;
    generate
        if (LOOP_PRESENT) begin : g_loop
            assign cand[12:4]  = route_s[ROUTE_W_LOOP-1:0];
            assign cand[15:13] = {clkop_reg && lock, secondary_loop_clock_out_reg, clkop_reg};
        end else begin : g_noloop
            assign cand[15:4]  = route_s;
        end
    endgenerate

    logic [NUM_NETS-1:0] prim_reg;
    logic [NUM_NETS-1:0] sec_reg;
    wire  [NUM_NETS-1:0] prim_next;
    wire  [NUM_NETS-1:0] sec_next;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_NETS; gi++) begin : g_net
            assign prim_next[gi] = cand[gsel_reg[gi*4 +: 4]];
            assign sec_next[gi]  = cand[gsel_reg[16 + gi*4 +: 4]];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prim_reg <= '0;
            sec_reg  <= '0;
        end else begin
            prim_reg <= prim_next;
            sec_reg  <= sec_next;
        end
    end

    logic lock_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lock_reg <= 1'b0;
        else
            lock_reg <= lock_state_reg == LK_LOCKED;
    end

    assign primary_clk              = prim_reg;
    assign secondary_clk            = sec_reg;
    assign primary_loop_clock_out   = clkop_reg;
    assign secondary_loop_clock_out = secondary_loop_clock_out_reg;
    assign lock                     = lock_reg;

endmodule // gcm_top

`default_nettype wire
